//--- hw/dls_store_ctrl.sv
// Control and status logic for the data logger store path.
// Assumes one clock, an AHB-Lite master, and a card writer on the same
// clock; the card detect pin arrives from outside and is synchronised.
// Software alone ends recording: nothing here ever lowers the start flag.
// The card writer must pulse done once per start, with fail and code.
`timescale 1ns/1ps
`default_nettype none
`include "dls_consts.svh"
module dls_store_ctrl
(
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Logger side.
	input wire logic sample_tick,
	input wire logic cfg_loaded,
	input wire logic card_cycle_mode,
	input wire logic card_detect,
	// Card writer side.
	output dls_pkg::dls_store_req_t store_req,
	input wire dls_pkg::dls_store_rsp_t store_rsp,
	// Recording enable and interrupt outputs.
	output logic recording,
	output logic irq_hold,
	output logic irq
);
	// Control bits written by software.
	logic start_q; // Recording enable, cleared only by software.
	logic activate_q; // Store activate level as last written.
	logic activate_prev_q; // Activate one cycle ago, for edge finding.
	logic [15:0] code_q; // Store control code.
	logic [31:0] limit_q; // Record count that triggers a store.

	// Status held by the block.
	logic [31:0] count_q; // Records captured since reset.
	logic storing_q; // A store to the card is under way.
	logic error_q; // The last store failed.
	logic [15:0] errcode_q; // Code of the last failed store.
	logic [3:0] irq_stat_q; // Sticky interrupt events.
	logic [3:0] irq_mask_q; // Interrupt enables, same layout.
	logic limit_prev_q; // Limit flag one cycle ago, for edge finding.
	dls_pkg::dls_state_t state_q; // Store sequencer state.

	// Card detect synchroniser.
	logic [2:0] det_sync_q; // Three-flop chain, oldest bit on top.
	logic present_q; // Filtered card present level.

	// Captured address phase.
	logic aph_valid_q; // A data phase is under way.
	logic aph_write_q; // That transfer is a write.
	logic [7:0] aph_addr_q; // And its byte address.

	// Limit condition derived from count and card mode.
	logic limit_flag; // Count at limit, or card in cycle mode.
	logic act_rise; // Activate went from off to on.
	logic store_go; // Every condition for a store start holds.
	logic rd_status; // The interrupt status is being read.
	logic [3:0] irq_events; // This cycle's events, status layout.

	// Word address match helper.
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] o);
		addr_is = (a[7:2] == o[7:2]);
	endfunction : addr_is

	// Limit reached at the configured count or while the card cycles.
	// Greater-or-equal, so a limit lowered below the count still reads on.
	assign limit_flag = (count_q >= limit_q) || card_cycle_mode;
	// A rising activate edge stores only under the key.
	// An edge that arrives while a store runs is lost, not queued.
	assign act_rise = activate_q && !activate_prev_q;
	// Store starts on a limit edge or a keyed activate edge.
	// The limit path also needs the key and a card, so a bad code never
	// starts a write on its own.
	assign store_go = (state_q == dls_pkg::DLS_IDLE) && present_q
		&& (code_q == `DLS_STORE_KEY)
		&& (act_rise
		|| (limit_flag && !limit_prev_q));
	// A completed read of the interrupt status clears it.
	// The clear lands at the end of the data phase, after the value left.
	assign rd_status = aph_valid_q && !aph_write_q
		&& addr_is(aph_addr_q, `DLS_OFF_IRQ_STAT);
	// Event vector in interrupt status layout.
	// The card bit fires once per filtered change of the detect level.
	always_comb
	begin
		irq_events = 4'h0;
		irq_events[`DLS_IRQ_STORE_DONE] = storing_q && store_rsp.done
			&& !store_rsp.fail;
		irq_events[`DLS_IRQ_STORE_ERR] = storing_q && store_rsp.done
			&& store_rsp.fail;
		irq_events[`DLS_IRQ_LIMIT] = limit_flag && !limit_prev_q;
		irq_events[`DLS_IRQ_CARD] = det_sync_q[2] != det_sync_q[1]
			? 1'b0 : (det_sync_q[2] != present_q);
	end

	// Card detect passes three flops; a change counts when two agree.
	// Only the first flop sees the raw pin; the rest see settled values.
	// Present starts low, so an inserted card raises one change event.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			det_sync_q <= 3'b000;
			present_q <= 1'b0;
		end
		else if (clk_en)
		begin
			det_sync_q <= {det_sync_q[1:0], card_detect};
			if (det_sync_q[2] == det_sync_q[1])
			begin
				present_q <= det_sync_q[2];
			end
		end
	end

	// Bus address phase capture; the slave is always ready.
	// Writes need hwdata, which stands one cycle later, hence the capture.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aph_valid_q <= 1'b0;
			aph_write_q <= 1'b0;
			aph_addr_q <= 8'h00;
		end
		else if (clk_en && hready)
		begin
			aph_valid_q <= hsel && htrans[1];
			aph_write_q <= hwrite;
			aph_addr_q <= haddr;
		end
	end

	// Software written control registers.
	// Writes land at the end of their data phase.
	// Activate is a level; only its rising edge matters downstream.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			start_q <= 1'b0;
			activate_q <= 1'b0;
			code_q <= 16'h0000;
			limit_q <= `DLS_LIMIT_RESET;
			irq_mask_q <= 4'h0;
		end
		else if (clk_en && aph_valid_q && aph_write_q)
		begin
			// Only writable words change; status words drop writes.
			if (addr_is(aph_addr_q, `DLS_OFF_CONTROL))
			begin
				// Only software ever changes the start flag.
				start_q <= hwdata[`DLS_BIT_START];
				activate_q <= hwdata[`DLS_BIT_ACTIVATE];
			end
			if (addr_is(aph_addr_q, `DLS_OFF_CODE))
			begin
				code_q <= hwdata[15:0];
			end
			if (addr_is(aph_addr_q, `DLS_OFF_LIMIT))
			begin
				limit_q <= hwdata;
			end
			if (addr_is(aph_addr_q, `DLS_OFF_IRQ_MASK))
			begin
				irq_mask_q <= hwdata[3:0];
			end
		end
	end

	// Record counter advances once for each sample while recording.
	// The count wraps silently after all ones; software must not rely
	// on it beyond that span.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count_q <= 32'h00000000;
		end
		else if (clk_en && start_q && sample_tick)
		begin
			count_q <= count_q + 32'h00000001;
		end
	end

	// Store sequencer and its status flags.
	// The error flag stays up until the next store starts, so software
	// may read the code at leisure.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= dls_pkg::DLS_IDLE;
			storing_q <= 1'b0;
			error_q <= 1'b0;
			errcode_q <= 16'h0000;
			activate_prev_q <= 1'b0;
			limit_prev_q <= 1'b0;
			store_req <= '0;
		end
		else if (clk_en)
		begin
			activate_prev_q <= activate_q;
			limit_prev_q <= limit_flag;
			store_req.start <= 1'b0;
			case (state_q)
				dls_pkg::DLS_IDLE:
				begin
					// Start the writer and snapshot the count.
					if (store_go)
					begin
						state_q <= dls_pkg::DLS_WAIT;
						storing_q <= 1'b1;
						error_q <= 1'b0;
						store_req.start <= 1'b1;
						store_req.count <= count_q;
					end
				end
				dls_pkg::DLS_WAIT:
				begin
					// Completion or failure both end the store.
					if (store_rsp.done)
					begin
						state_q <= dls_pkg::DLS_DONE;
						storing_q <= 1'b0;
						// A failure also records the writer's code.
						if (store_rsp.fail)
						begin
							error_q <= 1'b1;
							errcode_q <= store_rsp.code;
						end
					end
				end
				dls_pkg::DLS_DONE:
				begin
					// One pause so the same edge cannot restart a store.
					state_q <= dls_pkg::DLS_IDLE;
				end
				default:
				begin
					// A corrupted state code falls back to idle.
					state_q <= dls_pkg::DLS_IDLE;
				end
			endcase
		end
	end

	// Sticky interrupt status; a new event beats the read clear.
	// Set beats clear, so an event in the read cycle is never lost.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_stat_q <= 4'h0;
		end
		else if (clk_en)
		begin
			irq_stat_q <= (rd_status ? 4'h0 : irq_stat_q) | irq_events;
		end
	end

	// Registered outputs; the interrupt line is masked off while storing.
	// Every output lags the state it mirrors by one cycle, which keeps
	// all top-level outputs straight from flops.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq <= 1'b0;
			irq_hold <= 1'b0;
			recording <= 1'b0;
		end
		else if (clk_en)
		begin
			irq <= |(irq_stat_q & irq_mask_q) && !storing_q;
			irq_hold <= storing_q;
			recording <= start_q;
		end
	end

	// Read data is registered in the address phase for the data phase.
	// Registering here keeps hrdata off the decode path, at the cost of
	// showing status as it stood one cycle before the data phase.
	// The slave never stalls and never reports an error.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (clk_en && hready)
		begin
			// Unused bits and idle cycles read as zero.
			hrdata <= 32'h00000000;
			if (hsel && htrans[1] && !hwrite)
			begin
				case (haddr[7:2])
					// Status flags, all read-only.
					6'(`DLS_OFF_STATUS >> 2):
					begin
						hrdata[`DLS_BIT_PRESENT] <= present_q;
						hrdata[`DLS_BIT_STORING] <= storing_q;
						hrdata[`DLS_BIT_ERROR] <= error_q;
						hrdata[`DLS_BIT_LIMIT] <= limit_flag;
						hrdata[`DLS_BIT_CFGVALID] <= cfg_loaded;
					end
					// Control flags as last written.
					6'(`DLS_OFF_CONTROL >> 2):
					begin
						hrdata[`DLS_BIT_START] <= start_q;
						hrdata[`DLS_BIT_ACTIVATE] <= activate_q;
					end
					// Last failure code; it says nothing while no error.
					6'(`DLS_OFF_ERRCODE >> 2):
					begin
						hrdata[15:0] <= errcode_q;
					end
					// Record count and store settings.
					6'(`DLS_OFF_COUNT >> 2):
					begin
						hrdata <= count_q;
					end
					6'(`DLS_OFF_CODE >> 2):
					begin
						hrdata[15:0] <= code_q;
					end
					6'(`DLS_OFF_LIMIT >> 2):
					begin
						hrdata <= limit_q;
					end
					// Interrupt status and its mask.
					6'(`DLS_OFF_IRQ_STAT >> 2):
					begin
						hrdata[3:0] <= irq_stat_q;
					end
					6'(`DLS_OFF_IRQ_MASK >> 2):
					begin
						hrdata[3:0] <= irq_mask_q;
					end
					// Unmapped words read as zero.
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule : dls_store_ctrl
`default_nettype wire

//--- hw/dls_consts.svh
// Constants for the data logger store control block.
// Assumes inclusion by bare name from the design file.
`ifndef DLS_CONSTS_SVH
`define DLS_CONSTS_SVH
`define DLS_OFF_STATUS 8'h00
`define DLS_OFF_CONTROL 8'h04
`define DLS_OFF_ERRCODE 8'h08
`define DLS_OFF_COUNT 8'h0C
`define DLS_OFF_CODE 8'h10
`define DLS_OFF_LIMIT 8'h14
`define DLS_OFF_IRQ_STAT 8'h18
`define DLS_OFF_IRQ_MASK 8'h1C
`define DLS_BIT_PRESENT 0
`define DLS_BIT_STORING 1
`define DLS_BIT_ERROR 2
`define DLS_BIT_LIMIT 3
`define DLS_BIT_CFGVALID 4
`define DLS_BIT_START 0
`define DLS_BIT_ACTIVATE 1
`define DLS_STORE_KEY 16'h5AA5
`define DLS_LIMIT_RESET 32'hFFFFFFFF
`define DLS_IRQ_STORE_DONE 0
`define DLS_IRQ_STORE_ERR 1
`define DLS_IRQ_LIMIT 2
`define DLS_IRQ_CARD 3
`endif

//--- hw/dls_pkg.sv
// Types for the data logger store control block.
// Assumes the constants header is compiled alongside.
package dls_pkg;
	// Store sequencer states, one-hot.
	typedef enum logic [2:0]
	{
		DLS_IDLE = 3'b001,
		DLS_WAIT = 3'b010,
		DLS_DONE = 3'b100
	} dls_state_t;

	// Request toward the card writer.
	typedef struct packed
	{
		logic start;
		logic [31:0] count;
	} dls_store_req_t;

	// Answer from the card writer.
	typedef struct packed
	{
		logic done;
		logic fail;
		logic [15:0] code;
	} dls_store_rsp_t;
endpackage : dls_pkg

//--- tb/dls_card_model.sv
// Card writer model: answers every store start after a fixed delay.
// Assumes the controller's clock and its active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dls_card_model
(
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Store handshake.
	input wire dls_pkg::dls_store_req_t req,
	output dls_pkg::dls_store_rsp_t rsp,
	// Scenario controls and a start counter.
	input wire logic fail,
	input wire logic [15:0] code,
	output int starts
);
	int wait_q; // Cycles left in the write under way.
	// Outside done the code bus flips every cycle, so the stale code and its inverse alternate.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wait_q <= 0;
			rsp <= '0;
			starts <= 0;
		end
		else
		begin
			rsp.done <= (wait_q == 1);
			rsp.fail <= (wait_q == 1) && fail;
			rsp.code <= (wait_q == 1) ? code : ~rsp.code;
			wait_q <= req.start ? 20 : (wait_q > 0 ? wait_q - 1 : 0);
			starts <= starts + int'(req.start);
		end
	end
endmodule : dls_card_model
`default_nettype wire

//--- tb/dls_store_ctrl_assertions.sv
// Checker for the store controller's handshake and status outputs.
// Assumes the ports of the top module and the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module dls_store_ctrl_chk
(
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Watched ports.
	input wire logic card_detect,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire dls_pkg::dls_store_req_t store_req,
	input wire dls_pkg::dls_store_rsp_t store_rsp,
	input wire logic irq_hold,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_rdy; hreadyout && !hresp; endproperty
	a_rdy: assert property (p_rdy)
		else $error("bus stalled");
	property p_pulse; store_req.start |=> !store_req.start; endproperty
	a_pulse: assert property (p_pulse)
		else $error("long start");
	property p_hold; store_req.start |-> ##[0:1] irq_hold; endproperty
	a_hold: assert property (p_hold)
		else $error("no hold");
	property p_quiet; irq_hold && $past(irq_hold) |-> !irq; endproperty
	a_quiet: assert property (p_quiet)
		else $error("irq in store");
	property p_end; store_rsp.done && irq_hold |-> ##[1:2] !irq_hold;
	endproperty
	a_end: assert property (p_end)
		else $error("store stuck");
	property p_once; irq_hold && $past(irq_hold) |-> !store_req.start;
	endproperty
	a_once: assert property (p_once)
		else $error("restart");
	// The pin takes three flops and the presence filter one more before
	// a decision, so a start may still appear five samples after removal.
	property p_card; !card_detect [*6] |-> !store_req.start; endproperty
	a_card: assert property (p_card)
		else $error("no card");
	// Holding interrupts off only means something around a real store.
	property p_span; $rose(irq_hold) |-> irq_hold [*4]; endproperty
	a_span: assert property (p_span)
		else $error("short store");
endmodule : dls_store_ctrl_chk
bind dls_store_ctrl dls_store_ctrl_chk i_chk (.clk, .arst_n, .card_detect,
	.hreadyout, .hresp, .store_req, .store_rsp, .irq_hold, .irq);
`default_nettype wire

//--- tb/dls_store_ctrl_test.sv
// Self-checking bench for the store controller over AHB-Lite.
// Assumes the card writer model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "dls_consts.svh"
module dls_store_ctrl_test;
	logic clk = 0, arst_n = 0, hsel = 0, hwrite = 0, tick = 0, card = 1;
	logic fail = 0, cfg = 0, cyc = 0;
	logic [7:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic [31:0] hwdata = '0, hrdata, rd_q;
	logic hreadyout, hresp, recording, irq_hold, irq;
	dls_pkg::dls_store_req_t req;
	dls_pkg::dls_store_rsp_t rsp;
	int failures = 0, tests_run = 0, starts;
	initial forever #20 clk = ~clk;
	dls_store_ctrl i_dut (.clk, .arst_n, .clk_en(1'h1), .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .sample_tick(tick), .cfg_loaded(cfg),
		.card_cycle_mode(cyc), .card_detect(card), .store_req(req),
		.store_rsp(rsp), .recording, .irq_hold, .irq);
	dls_card_model i_card (.clk, .arst_n, .req, .rsp, .fail,
		.code(16'h0042), .starts);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : check
	// One single transfer; a wait loop that never sees ready ends only by the watchdog.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		rd_q = hrdata;
	endtask : xfer
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, '0);
		check(rd_q, e);
	endtask : rdchk
	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge clk);
			tick <= 1'h1;
			@(posedge clk);
			tick <= 1'h0;
		end
	endtask : ticks
	// Fires the activate edge, then lets the store run out.
	task automatic store;
		xfer(1'h1, `DLS_OFF_CONTROL, 32'h1);
		xfer(1'h1, `DLS_OFF_CONTROL, 32'h3);
		repeat (4) @(posedge clk);
		while (irq_hold === 1'h1) @(posedge clk);
		repeat (2) @(posedge clk);
	endtask : store
	task automatic t_regs;
		rdchk(`DLS_OFF_LIMIT, `DLS_LIMIT_RESET);
		rdchk(`DLS_OFF_STATUS, 32'h1);
		cfg <= 1'h1;
		xfer(1'h1, `DLS_OFF_STATUS, 32'hFFFF);
		xfer(1'h1, `DLS_OFF_COUNT, 32'h5);
		rdchk(`DLS_OFF_STATUS, 32'h11);
		rdchk(`DLS_OFF_COUNT, 32'h0);
		rdchk(8'h20, 32'h0);
		xfer(1'h1, `DLS_OFF_IRQ_MASK, 32'h1);
	endtask : t_regs
	task automatic t_count;
		xfer(1'h1, `DLS_OFF_CONTROL, 32'h1);
		ticks(3);
		rdchk(`DLS_OFF_COUNT, 32'h3);
		check(recording, 1'h1);
		xfer(1'h1, `DLS_OFF_CONTROL, 32'h0);
		ticks(1);
		rdchk(`DLS_OFF_COUNT, 32'h3);
		xfer(1'h1, `DLS_OFF_CONTROL, 32'h1);
		rdchk(`DLS_OFF_CONTROL, 32'h1);
	endtask : t_count
	task automatic t_store;
		xfer(1'h1, `DLS_OFF_CODE, 32'h1234);
		store();
		check(starts, 0);
		xfer(1'h1, `DLS_OFF_CODE, {16'h0, `DLS_STORE_KEY});
		xfer(1'h1, `DLS_OFF_CONTROL, 32'h1);
		xfer(1'h1, `DLS_OFF_CONTROL, 32'h3);
		repeat (3) @(posedge clk);
		check(irq_hold, 1'h1);
		rdchk(`DLS_OFF_STATUS, 32'h13);
		store();
		check(starts, 1);
		rdchk(`DLS_OFF_STATUS, 32'h11);
		check(irq, 1'h1);
		xfer(1'h0, `DLS_OFF_IRQ_STAT, '0);
		check(rd_q[0], 1'h1);
		repeat (2) @(posedge clk);
		check(irq, 1'h0);
		fail <= 1'h1;
		store();
		rdchk(`DLS_OFF_STATUS, 32'h15);
		rdchk(`DLS_OFF_ERRCODE, 32'h42);
		fail <= 1'h0;
	endtask : t_store
	task automatic t_limit;
		xfer(1'h1, `DLS_OFF_LIMIT, 32'h5);
		xfer(1'h1, `DLS_OFF_CONTROL, 32'h1);
		ticks(2);
		repeat (4) @(posedge clk);
		check(starts, 3);
		while (irq_hold === 1'h1) @(posedge clk);
		check(req.count, 32'h5);
		rdchk(`DLS_OFF_STATUS, 32'h19);
	endtask : t_limit
	task automatic t_card;
		card <= 1'h0;
		repeat (8) @(posedge clk);
		store();
		check(starts, 3);
		rdchk(`DLS_OFF_STATUS, 32'h18);
		xfer(1'h1, `DLS_OFF_LIMIT, `DLS_LIMIT_RESET);
		rdchk(`DLS_OFF_STATUS, 32'h10);
		cyc <= 1'h1;
		rdchk(`DLS_OFF_STATUS, 32'h18);
	endtask : t_card
	task automatic results;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	initial
	begin
		repeat (8) @(posedge clk);
		arst_n <= 1'h1;
		t_regs();
		t_count();
		t_store();
		t_limit();
		t_card();
		results();
	end
	// A hung handshake counts as a failure.
	initial
	begin
		#200000;
		failures++;
		results();
	end
endmodule : dls_store_ctrl_test
`default_nettype wire
